// ---- ltd_fetch_model.sv ----
// Program fetch, data memory, table memory and write-cycle partner model
`timescale 1ns/1ns
module ltd_fetch_model
  import ltd_pkg::*;
(
  // Clock
  input  wire logic          hclk,
  // Fetch path
  input  wire logic          instr_ready,
  output logic               instr_valid,
  output logic [15:0]        instr_word,
  // Data and table memory
  input  wire ltd_dmem_req_t dmem,
  output logic [7:0]         dmem_rdata,
  input  wire ltd_tbl_req_t  tbl,
  output logic [7:0]         tbl_rdata,
  // Write cycle
  input  wire logic          nvm_start,
  output logic               nvm_done
);
  logic [15:0]   q[$];
  logic [7:0]    mem[4096];
  logic [7:0]    wr_data;
  logic          tk = 1'b0;
  logic          ns = 1'b0;
  ltd_dmem_req_t dm = '0;
  ltd_tbl_req_t  tr = '0;
  int            wcnt = 0;
  initial begin
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    dmem_rdata  = 8'h00;
    tbl_rdata   = 8'h00;
    nvm_done    = 1'b0;
    wr_data     = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h3c;
  end
  // Requests are sampled mid-cycle, where they have settled
  always @(negedge hclk) begin
    tk = instr_valid && instr_ready;
    dm = dmem;
    tr = tbl;
    ns = nvm_start;
  end
  // Lines outside their valid clock show changing junk
  always @(posedge hclk) begin
    if (tk) void'(q.pop_front());
    instr_valid <= (q.size() != 0);
    instr_word  <= (q.size() != 0) ? q[0] : ~instr_word;
    dmem_rdata  <= dm.re ? mem[dm.addr] : ~dmem_rdata;
    tbl_rdata   <= tr.rd ? (tr.addr[7:0] ^ 8'ha5) : ~tbl_rdata;
    if (dm.we) mem[dm.addr] = dm.wdata;
    if (tr.wr) wr_data = tr.wdata;
    wcnt = ns ? 40 : (wcnt > 0 ? wcnt - 1 : 0);
    nvm_done <= (wcnt == 1);
  end
endmodule : ltd_fetch_model

// ---- ltd_literal_table_decoder.sv ----
// Literal, table and register-xor instruction decode and execute with an AHB-Lite register view
//
// Summary of operation
// - Add literal to accumulator, all five flags
// - AND literal with accumulator, zero and negative
// - OR literal with accumulator, zero and negative
// - XOR literal with accumulator, zero and negative
// - Literal minus accumulator, all five flags
// - Load literal into accumulator, flags untouched
// - Multiply literal by accumulator, flags untouched
// - Return loading literal, two cycles, no flags
// - Bank load writes four-bit bank select
// - Two-word pointer load builds twelve-bit value
// - Table read, two cycles, four pointer modes
// - Table write, two cycles or five
// - Started memory write runs until terminated
// - Unconsumed second word executes as no-op
// - Program-counter change adds a no-op cycle
// - Port self-update reads pin levels
// - Timer-zero write clears assigned prescaler
// - Register xor updates negative and zero only
`timescale 1ns/1ns
`include "ltd_map.svh"
module ltd_literal_table_decoder
  import ltd_pkg::*;
#(
  parameter int          TBLPTR_W  = 21,
  parameter logic [11:0] PORT_ADDR = 12'hf80,
  parameter logic [11:0] TIMER_ZERO_COUNT_ADDR = 12'hf90
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Program memory fetch path
  input  wire logic          instr_valid,
  input  wire logic [15:0]   instr_word,
  output logic               instr_ready,
  output logic               fetch_flush,
  output logic               ret_pop,
  // Data memory
  output ltd_dmem_req_t      dmem,
  input  wire logic [7:0]    dmem_rdata,
  // Port pins and timer zero
  input  wire logic [7:0]    port_pins,
  output logic               presc_clear,
  // Table and nonvolatile memory
  output ltd_tbl_req_t       tbl,
  input  wire logic [7:0]    tbl_rdata,
  output logic               nvm_start,
  input  wire logic          nvm_done,
  output logic               nvm_busy
);
  if (TBLPTR_W < 8 || TBLPTR_W > 24) begin : g_chk
    $error("TBLPTR_W must lie between 8 and 24");
  end

  ltd_state_t            st_reg;
  logic [1:0]            ph_reg;
  logic [2:0]            cyc_reg;
  logic [2:0]            last_reg;
  logic [15:0]           ir_reg;
  logic                  nvm_go_reg;
  logic                  nvm_busy_reg;
  ltd_op_t               op;
  ltd_op_t               op_in;
  logic [7:0]            acc_reg;
  ltd_flags_t            flags_reg;
  logic [3:0]            bank_reg;
  logic [11:0]           ptr_reg [3];
  logic [TBLPTR_W-1:0]   tblptr_reg;
  logic [7:0]            tablat_reg;
  logic [15:0]           prod_reg;
  logic [1:0]            ctrl_reg;
  logic [7:0]            dsrc_reg;
  logic [7:0]            pin_meta_reg;
  logic [7:0]            pin_sync_reg;
  logic                  exec0;
  logic                  accept;
  logic [7:0]            k;
  logic [7:0]            alu_res;
  ltd_flags_t            alu_flags;
  logic [8:0]            sum9;
  logic [4:0]            sum5;
  logic [7:0]            src_now;
  logic                  a_ph;
  logic                  wr_pend_reg;
  logic [7:0]            ha_reg;
  logic [31:0]           rd_val;

  function automatic ltd_op_t decode(input logic [15:0] w);
    ltd_op_t o;
    o = OP_NOP;
    case (w[15:8])
      `LTD_OPC_ADD: o = OP_ADD;
      `LTD_OPC_AND: o = OP_AND;
      `LTD_OPC_OR:  o = OP_OR;
      `LTD_OPC_XOR: o = OP_XOR;
      `LTD_OPC_SUB: o = OP_SUB;
      `LTD_OPC_MOV: o = OP_MOV;
      `LTD_OPC_MUL: o = OP_MUL;
      `LTD_OPC_RET: o = OP_RET;
      default:      o = OP_NOP;
    endcase
    if (w[15:4] == `LTD_OPC_BANK) o = OP_BANK;
    if (w[15:6] == `LTD_OPC_PTR) o = OP_PTR;
    if (w[15:4] == `LTD_OPC_TBL && w[`LTD_BIT_TBL])
      o = w[`LTD_BIT_TABLE_WRITE_OP] ? OP_TABLE_WRITE_OP : OP_TABLE_READ_OP;
    if (w[15:10] == `LTD_OPC_XORF) o = OP_XORF;
    return o;
  endfunction : decode

  function automatic logic [2:0] last_cycle(input ltd_op_t o, input logic go);
    logic [2:0] n;
    n = 3'd0;
    case (o)
      OP_RET, OP_TABLE_READ_OP, OP_PTR: n = 3'(`LTD_CYC_TWO - 1);
      OP_TABLE_WRITE_OP:                 n = go ? 3'(`LTD_CYC_NVM - 1) : 3'(`LTD_CYC_TWO - 1);
      default:                  n = 3'd0;
    endcase
    return n;
  endfunction : last_cycle

  assign op_in       = decode(instr_word);
  assign op          = decode(ir_reg);
  assign k           = ir_reg[7:0];
  assign accept      = instr_valid && (st_reg == ST_WAIT);
  assign exec0       = (st_reg == ST_EXEC) && (ph_reg == 2'(`LTD_Q_PHASES - 1)) && (cyc_reg == 3'd0);
  assign instr_ready = (st_reg == ST_WAIT) || (st_reg == ST_WORD2);
  assign nvm_busy    = nvm_busy_reg;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;

  // Sequencer: Q1 is the cycle in which the word is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg     <= ST_WAIT;
      ph_reg     <= 2'd0;
      cyc_reg    <= 3'd0;
      last_reg   <= 3'd0;
      ir_reg     <= 16'h0000;
      nvm_go_reg <= 1'b0;
    end else begin
      case (st_reg)
        ST_WAIT: begin
          if (instr_valid) begin
            ir_reg     <= instr_word;
            st_reg     <= ST_EXEC;
            ph_reg     <= 2'd1;
            cyc_reg    <= 3'd0;
            nvm_go_reg <= ctrl_reg[`LTD_CTRL_NVM] && !nvm_busy_reg;
            last_reg   <= last_cycle(op_in, ctrl_reg[`LTD_CTRL_NVM] && !nvm_busy_reg);
          end
        end
        ST_EXEC: begin
          ph_reg <= ph_reg + 2'd1;
          if (ph_reg == 2'(`LTD_Q_PHASES - 1)) begin
            if (cyc_reg == last_reg) begin
              st_reg <= ST_WAIT;
            end else begin
              cyc_reg <= cyc_reg + 3'd1;
              if (op == OP_PTR) st_reg <= ST_WORD2;
            end
          end
        end
        ST_WORD2: begin
          if (instr_valid) begin
            st_reg <= ST_EXEC;
            ph_reg <= 2'd1;
          end
        end
        default: st_reg <= ST_WAIT;
      endcase
    end
  end

  // Pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= port_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign src_now = (dmem.addr == PORT_ADDR) ? pin_sync_reg : dmem_rdata;

  // Arithmetic and logic unit
  always_comb begin
    alu_flags = flags_reg;
    alu_res   = acc_reg;
    sum9      = 9'h000;
    sum5      = 5'h00;
    case (op)
      OP_ADD: begin
        sum9        = {1'b0, acc_reg} + {1'b0, k};
        sum5        = {1'b0, acc_reg[3:0]} + {1'b0, k[3:0]};
        alu_res     = sum9[7:0];
        alu_flags.c = sum9[8];
        alu_flags.dc = sum5[4];
        alu_flags.ov = (acc_reg[7] == k[7]) && (alu_res[7] != k[7]);
      end
      OP_SUB: begin
        sum9        = {1'b0, k} + {1'b0, ~acc_reg} + 9'h001;
        sum5        = {1'b0, k[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
        alu_res     = sum9[7:0];
        alu_flags.c = sum9[8];
        alu_flags.dc = sum5[4];
        alu_flags.ov = (k[7] != acc_reg[7]) && (alu_res[7] != k[7]);
      end
      OP_AND:  alu_res = acc_reg & k;
      OP_OR:   alu_res = acc_reg | k;
      OP_XOR:  alu_res = acc_reg ^ k;
      OP_XORF: alu_res = acc_reg ^ dsrc_reg;
      default: alu_res = acc_reg;
    endcase
    alu_flags.z = (alu_res == 8'h00);
    alu_flags.n = alu_res[7];
  end

  // Accumulator, flags, bank and product
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg   <= `LTD_RST_ACC;
      flags_reg <= `LTD_RST_FLAGS;
      bank_reg  <= `LTD_RST_BANK;
      prod_reg  <= 16'h0000;
    end else if (exec0) begin
      case (op)
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
          acc_reg   <= alu_res;
          flags_reg <= (op == OP_ADD || op == OP_SUB) ? alu_flags
                       : ltd_flags_t'{n: alu_flags.n, ov: flags_reg.ov, z: alu_flags.z,
                                      dc: flags_reg.dc, c: flags_reg.c};
        end
        OP_MOV:  acc_reg <= k;
        OP_RET:  acc_reg <= k;
        OP_MUL:  prod_reg <= acc_reg * k;
        OP_BANK: bank_reg <= k[3:0];
        OP_XORF: begin
          if (!ir_reg[`LTD_BIT_DEST]) acc_reg <= alu_res;
          flags_reg.z <= alu_flags.z;
          flags_reg.n <= alu_flags.n;
        end
        default: acc_reg <= acc_reg;
      endcase
    end else if (wr_pend_reg) begin
      case (ha_reg)
        `LTD_OFF_ACC:    acc_reg   <= hwdata[7:0];
        `LTD_OFF_STATUS: flags_reg <= hwdata[4:0];
        `LTD_OFF_BANK:   bank_reg  <= hwdata[3:0];
        default:         acc_reg   <= acc_reg;
      endcase
    end
  end

  // Return and flush pulses in the no-op second cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_pop     <= 1'b0;
      fetch_flush <= 1'b0;
    end else begin
      ret_pop     <= exec0 && (op == OP_RET);
      fetch_flush <= exec0 && (op == OP_RET);
    end
  end

  // Indirect pointers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) ptr_reg[i] <= 12'h000;
    end else if (st_reg == ST_WORD2 && instr_valid && ir_reg[5:4] != 2'b11) begin
      // join upper nibble and low byte
      ptr_reg[ir_reg[5:4]] <= {ir_reg[3:0], instr_word[7:0]};
    end
  end

  // Register path over four phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmem        <= '0;
      dsrc_reg    <= 8'h00;
      presc_clear <= 1'b0;
    end else begin
      presc_clear <= 1'b0;
      dmem.we     <= 1'b0;
      if (accept && op_in == OP_XORF) begin
        dmem.addr <= instr_word[`LTD_BIT_BANKED] ? {bank_reg, instr_word[7:0]}
                     : {{4{instr_word[7]}}, instr_word[7:0]};
        dmem.re   <= 1'b1;
      end else begin
        dmem.re   <= 1'b0;
      end
      if (st_reg == ST_EXEC && ph_reg == 2'd2 && cyc_reg == 3'd0 && op == OP_XORF) begin
        dsrc_reg    <= src_now;
        dmem.wdata  <= acc_reg ^ src_now;
        dmem.we     <= ir_reg[`LTD_BIT_DEST];
        presc_clear <= ir_reg[`LTD_BIT_DEST] && (dmem.addr == TIMER_ZERO_COUNT_ADDR)
                       && ctrl_reg[`LTD_CTRL_PRESC];
      end
    end
  end

  // Table pointer, latch and memory strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbl        <= '0;
      tblptr_reg <= '0;
      tablat_reg <= 8'h00;
      nvm_start  <= 1'b0;
    end else begin
      tbl.rd    <= 1'b0;
      tbl.wr    <= 1'b0;
      nvm_start <= 1'b0;
      if (exec0 && (op == OP_TABLE_READ_OP || op == OP_TABLE_WRITE_OP)) begin
        tbl.addr  <= 24'((ir_reg[1:0] == `LTD_TBL_PREINC) ? tblptr_reg + 1'b1 : tblptr_reg);
        tbl.wdata <= tablat_reg;
        tbl.rd    <= (op == OP_TABLE_READ_OP);
        tbl.wr    <= (op == OP_TABLE_WRITE_OP);
        nvm_start <= (op == OP_TABLE_WRITE_OP) && nvm_go_reg;
        case (ir_reg[1:0])
          `LTD_TBL_POSTINC, `LTD_TBL_PREINC: tblptr_reg <= tblptr_reg + 1'b1;
          `LTD_TBL_POSTDEC:                  tblptr_reg <= tblptr_reg - 1'b1;
          default:                           tblptr_reg <= tblptr_reg;
        endcase
      end else if (wr_pend_reg && ha_reg == `LTD_OFF_TBLPTR) begin
        tblptr_reg <= hwdata[TBLPTR_W-1:0];
      end
      if (st_reg == ST_EXEC && cyc_reg == 3'd1 && ph_reg == 2'd1 && op == OP_TABLE_READ_OP) begin
        tablat_reg <= tbl_rdata;
      end else if (wr_pend_reg && ha_reg == `LTD_OFF_TBLLAT) begin
        tablat_reg <= hwdata[7:0];
      end
    end
  end

  // Memory write busy; start beats done, control bits cannot abort
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_busy_reg <= 1'b0;
    end else if (nvm_start) begin
      nvm_busy_reg <= 1'b1;
    end else if (nvm_done) begin
      nvm_busy_reg <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `LTD_RST_CTRL;
    end else if (wr_pend_reg && ha_reg == `LTD_OFF_CTRL) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // Bus slave: zero wait states, read data registered at the address phase
  assign a_ph = hsel && htrans[1] && hready;

  always_comb begin
    case (haddr[7:0])
      `LTD_OFF_ACC:    rd_val = {24'h000000, acc_reg};
      `LTD_OFF_STATUS: rd_val = {27'h0000000, flags_reg};
      `LTD_OFF_BANK:   rd_val = {28'h0000000, bank_reg};
      `LTD_OFF_PTR0:   rd_val = {20'h00000, ptr_reg[0]};
      `LTD_OFF_PTR1:   rd_val = {20'h00000, ptr_reg[1]};
      `LTD_OFF_PTR2:   rd_val = {20'h00000, ptr_reg[2]};
      `LTD_OFF_TBLPTR: rd_val = 32'(tblptr_reg);
      `LTD_OFF_TBLLAT: rd_val = {24'h000000, tablat_reg};
      `LTD_OFF_PROD:   rd_val = {16'h0000, prod_reg};
      `LTD_OFF_CTRL:   rd_val = {30'h00000000, ctrl_reg};
      `LTD_OFF_STATE:  rd_val = {29'h00000000, nvm_busy_reg, st_reg};
      default:         rd_val = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) rd_val = 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      ha_reg      <= 8'h00;
      hrdata      <= 32'h00000000;
    end else begin
      wr_pend_reg <= a_ph && hwrite && (haddr[31:8] == 24'h000000);
      if (a_ph) ha_reg <= haddr[7:0];
      if (a_ph && !hwrite) hrdata <= rd_val;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ret_start;
    exec0 && op == OP_RET;
  endsequence
  sequence s_xorf_take;
    accept && op_in == OP_XORF;
  endsequence

  property p_add_acc;
    exec0 && op == OP_ADD |=> acc_reg == 8'($past(acc_reg) + $past(k));
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add result wrong");
  property p_and_keep;
    exec0 && (op == OP_AND || op == OP_OR || op == OP_XOR)
      |=> {flags_reg.c, flags_reg.dc, flags_reg.ov}
          == $past({flags_reg.c, flags_reg.dc, flags_reg.ov});
  endproperty
  a_and_keep: assert property (p_and_keep) else $error("logic op touched carry");
  property p_sub_acc;
    exec0 && op == OP_SUB |=> acc_reg == 8'($past(k) - $past(acc_reg));
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract order wrong");
  property p_mov;
    exec0 && op == OP_MOV |=> acc_reg == $past(k) && $stable(flags_reg);
  endproperty
  a_mov: assert property (p_mov) else $error("load changed flags");
  property p_ret;
    s_ret_start |=> ret_pop ##1 !ret_pop ##3 (st_reg == ST_WAIT);
  endproperty
  a_ret: assert property (p_ret) else $error("return not two cycles");
  property p_bank;
    exec0 && op == OP_BANK |=> bank_reg == $past(k[3:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load wrong");
  property p_table_read_op;
    exec0 && op == OP_TABLE_READ_OP |=> tbl.rd ##1 !tbl.rd ##1 tablat_reg == $past(tbl_rdata);
  endproperty
  a_table_read_op: assert property (p_table_read_op) else $error("table read latch wrong");
  property p_table_write_op_len;
    exec0 && op == OP_TABLE_WRITE_OP && nvm_go_reg |-> ##16 (st_reg == ST_EXEC) ##1 (st_reg == ST_WAIT);
  endproperty
  a_table_write_op_len: assert property (p_table_write_op_len) else $error("long table write not five");
  property p_nvm_hold;
    nvm_busy_reg && !nvm_done |=> nvm_busy_reg;
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("memory write abandoned");
  property p_orphan;
    accept && instr_word[15:8] == `LTD_OPC_PTR2 |=> (st_reg == ST_EXEC)[*3]
      ##1 (st_reg == ST_WAIT && $stable(acc_reg) && $stable(flags_reg));
  endproperty
  a_orphan: assert property (p_orphan) else $error("second word not a no-op");
  property p_xorf;
    s_xorf_take |=> dmem.re ##1 !dmem.re ##1 dmem.we == ir_reg[`LTD_BIT_DEST];
  endproperty
  a_xorf: assert property (p_xorf) else $error("register phases wrong");
  property p_presc;
    st_reg == ST_EXEC && ph_reg == 2'd2 && cyc_reg == 3'd0 && op == OP_XORF
      && ir_reg[`LTD_BIT_DEST] && dmem.addr == TIMER_ZERO_COUNT_ADDR && ctrl_reg[`LTD_CTRL_PRESC]
      |=> presc_clear;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");
endmodule : ltd_literal_table_decoder

// ---- ltd_literal_table_decoder_tb.sv ----
// Self-checking bench for the literal/table decoder
`timescale 1ns/1ns
`include "ltd_map.svh"
module ltd_literal_table_decoder_tb;
  import ltd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid, instr_ready;
  logic fetch_flush, ret_pop, presc_clear, nvm_start, nvm_done, nvm_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] instr_word;
  logic [7:0]  dmem_rdata, port_pins, tbl_rdata;
  ltd_dmem_req_t dmem;
  ltd_tbl_req_t  tbl;
  int n_mismatch = 0, n_checks = 0, n_cyc = 0, n_pc = 0, n_rp = 0;
  localparam logic [7:0] OPS [10] = '{`LTD_OPC_ADD, `LTD_OPC_ADD, `LTD_OPC_SUB, `LTD_OPC_SUB,
    `LTD_OPC_AND, `LTD_OPC_OR, `LTD_OPC_XOR, `LTD_OPC_MOV, `LTD_OPC_MUL, `LTD_OPC_RET};
  localparam logic [7:0] AS [10] = '{8'h7f, 8'hff, 8'h05, 8'h03, 8'hf0, 8'h0f, 8'hff, 8'haa,
    8'h12, 8'h00};
  localparam logic [7:0] KS [10] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h3c, 8'h80, 8'hff, 8'h00,
    8'h34, 8'h9c};
  ltd_literal_table_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .fetch_flush(fetch_flush),
    .ret_pop(ret_pop), .dmem(dmem), .dmem_rdata(dmem_rdata), .port_pins(port_pins),
    .presc_clear(presc_clear), .tbl(tbl), .tbl_rdata(tbl_rdata), .nvm_start(nvm_start),
    .nvm_done(nvm_done), .nvm_busy(nvm_busy));
  ltd_fetch_model fm_u (.hclk(hclk), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word), .dmem(dmem), .dmem_rdata(dmem_rdata), .tbl(tbl),
    .tbl_rdata(tbl_rdata), .nvm_start(nvm_start), .nvm_done(nvm_done));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (presc_clear === 1'b1) n_pc++;
    if (ret_pop === 1'b1 && fetch_flush === 1'b1) n_rp++;
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask : rchk
  // Runs one instruction and returns its length in instruction cycles
  task automatic ex(input logic [15:0] w, output logic [31:0] cyc);
    int n;
    n = 0;
    fm_u.q.push_back(w);
    while (fm_u.q.size() != 0) @(negedge hclk);
    while (instr_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge hclk);
    end
    cyc = 32'((n + 1) / 4);
  endtask : ex
  task automatic t_lit;
    logic [7:0] a, k, op, y, r;
    logic [8:0] s;
    logic [4:0] h, f;
    logic [15:0] p;
    logic [31:0] c;
    for (int i = 0; i < 10; i++) begin
      a = AS[i];
      k = KS[i];
      op = OPS[i];
      y = (op == `LTD_OPC_SUB) ? ~a : a;
      s = {1'b0, k} + {1'b0, y} + {8'h0, op == `LTD_OPC_SUB};
      h = {1'b0, k[3:0]} + {1'b0, y[3:0]} + {4'h0, op == `LTD_OPC_SUB};
      p = a * k;
      f = 5'h1f;
      r = (op == `LTD_OPC_MUL) ? a : k;
      if (op == `LTD_OPC_ADD || op == `LTD_OPC_SUB) begin
        r = s[7:0];
        f = {r[7], (k[7] == y[7]) && (r[7] != k[7]), r == 8'h00, h[4], s[8]};
      end
      if (op == `LTD_OPC_AND) r = a & k;
      if (op == `LTD_OPC_OR) r = a | k;
      if (op == `LTD_OPC_XOR) r = a ^ k;
      if (op inside {`LTD_OPC_AND, `LTD_OPC_OR, `LTD_OPC_XOR}) f[4:2] = {r[7], 1'b1, r == 8'h00};
      wr(`LTD_OFF_ACC, {24'h0, a});
      wr(`LTD_OFF_STATUS, 32'h1f);
      ex({op, k}, c);
      chk(c, (op == `LTD_OPC_RET) ? 32'd2 : 32'd1);
      rchk(`LTD_OFF_ACC, {24'h0, r});
      rchk(`LTD_OFF_STATUS, {27'h0, f});
      if (op == `LTD_OPC_MUL) rchk(`LTD_OFF_PROD, {16'h0, p});
    end
    chk(32'(n_rp), 32'd1);
    $display("test literal ops done");
  endtask : t_lit
  task automatic t_misc;
    logic [31:0] c;
    ex(16'h010a, c);
    rchk(`LTD_OFF_BANK, 32'h0a);
    for (int i = 0; i < 3; i++) begin
      fm_u.q.push_back({8'hee, 2'b00, i[1:0], i[3:0] + 4'h3});
      ex(16'hf0c5, c);
      rchk(8'(`LTD_OFF_PTR0 + 4 * i), {20'h0, i[3:0] + 4'h3, 8'hc5});
    end
    wr(`LTD_OFF_ACC, 32'h33);
    ex(16'hf012, c);
    chk(c, 32'd1);
    rchk(`LTD_OFF_ACC, 32'h33);
    $display("test bank pointer done");
  endtask : t_misc
  task automatic t_tbl;
    logic [31:0] c;
    logic [23:0] ad[4] = '{24'h120, 24'h120, 24'h120, 24'h121};
    logic [23:0] nx[4] = '{24'h120, 24'h121, 24'h11f, 24'h121};
    for (int m = 0; m < 4; m++) begin
      wr(`LTD_OFF_TBLPTR, 32'h120);
      ex(16'h0008 | 16'(m), c);
      chk(c, 32'd2);
      rchk(`LTD_OFF_TBLLAT, {24'h0, ad[m][7:0] ^ 8'ha5});
      rchk(`LTD_OFF_TBLPTR, {8'h0, nx[m]});
    end
    wr(`LTD_OFF_TBLLAT, 32'h5c);
    ex(16'h000d, c);
    chk(c, 32'd2);
    chk({24'h0, fm_u.wr_data}, 32'h5c);
    wr(`LTD_OFF_CTRL, 32'h2);
    ex(16'h000c, c);
    chk(c, 32'd5);
    wr(`LTD_OFF_CTRL, 32'h0);
    rchk(`LTD_OFF_STATE, 32'h4);
    chk({31'h0, nvm_busy}, 32'h1);
    repeat (40) @(posedge hclk);
    rchk(`LTD_OFF_STATE, 32'h0);
    chk({31'h0, nvm_busy}, 32'h0);
    $display("test table ops done");
  endtask : t_tbl
  task automatic t_xorf;
    logic [31:0] c;
    wr(`LTD_OFF_BANK, 32'h1);
    wr(`LTD_OFF_ACC, 32'h0f);
    wr(`LTD_OFF_STATUS, 32'h1f);
    ex(16'h1923, c);
    chk(c, 32'd1);
    rchk(`LTD_OFF_ACC, 32'h10);
    rchk(`LTD_OFF_STATUS, 32'h0b);
    ex(16'h1a80, c);
    chk({24'h0, fm_u.mem[12'hf80]}, 32'h86);
    rchk(`LTD_OFF_ACC, 32'h10);
    wr(`LTD_OFF_CTRL, 32'h1);
    ex(16'h1a90, c);
    chk(32'(n_pc), 32'd1);
    $display("test register xor done");
  endtask : t_xorf
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    port_pins = 8'h96;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`LTD_OFF_ACC, 32'h0);
    rchk(`LTD_OFF_STATUS, 32'h0);
    rchk(`LTD_OFF_BANK, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(8'h40, 32'h5a);
    rchk(8'h40, 32'h0);
    $display("test reset values done");
    t_lit();
    t_misc();
    t_tbl();
    t_xorf();
    conclude();
  end
endmodule : ltd_literal_table_decoder_tb

// ---- ltd_map.svh ----
// Register offsets, opcode fields, reset values and cycle counts of the literal/table decoder
`ifndef LTD_MAP_SVH
`define LTD_MAP_SVH
// Register byte offsets
`define LTD_OFF_ACC     8'h00
`define LTD_OFF_STATUS  8'h04
`define LTD_OFF_BANK    8'h08
`define LTD_OFF_PTR0    8'h0c
`define LTD_OFF_PTR1    8'h10
`define LTD_OFF_PTR2    8'h14
`define LTD_OFF_TBLPTR  8'h18
`define LTD_OFF_TBLLAT  8'h1c
`define LTD_OFF_PROD    8'h20
`define LTD_OFF_CTRL    8'h24
`define LTD_OFF_STATE   8'h28
// Reset values
`define LTD_RST_ACC     8'h00
`define LTD_RST_FLAGS   5'h00
`define LTD_RST_BANK    4'h0
`define LTD_RST_CTRL    2'h0
// Control register fields
`define LTD_CTRL_PRESC  0
`define LTD_CTRL_NVM    1
// Opcode fields
`define LTD_OPC_ADD     8'h0f
`define LTD_OPC_AND     8'h0b
`define LTD_OPC_OR      8'h09
`define LTD_OPC_XOR     8'h0a
`define LTD_OPC_SUB     8'h08
`define LTD_OPC_MOV     8'h0e
`define LTD_OPC_MUL     8'h0d
`define LTD_OPC_RET     8'h0c
`define LTD_OPC_BANK    12'h010
`define LTD_OPC_PTR     10'h3b8
`define LTD_OPC_PTR2    8'hf0
`define LTD_OPC_TBL     12'h000
`define LTD_OPC_XORF    6'h06
// Instruction word field positions
`define LTD_BIT_TBL     3
`define LTD_BIT_TABLE_WRITE_OP   2
`define LTD_BIT_DEST    9
`define LTD_BIT_BANKED  8
// Table pointer update modes
`define LTD_TBL_NONE    2'b00
`define LTD_TBL_POSTINC 2'b01
`define LTD_TBL_POSTDEC 2'b10
`define LTD_TBL_PREINC  2'b11
// Timing, in instruction cycles of four clocks
`define LTD_Q_PHASES    4
`define LTD_CYC_TWO     2
`define LTD_CYC_NVM     5
`endif

// ---- ltd_pkg.sv ----
// Types shared by the literal/table decoder
package ltd_pkg;
  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_WORD2 = 2'b10
  } ltd_state_t;
  typedef enum logic [3:0] {
    OP_NOP   = 4'b0000,
    OP_ADD   = 4'b0001,
    OP_AND   = 4'b0010,
    OP_OR    = 4'b0011,
    OP_XOR   = 4'b0100,
    OP_SUB   = 4'b0101,
    OP_MOV   = 4'b0110,
    OP_MUL   = 4'b0111,
    OP_RET   = 4'b1000,
    OP_BANK  = 4'b1001,
    OP_PTR   = 4'b1010,
    OP_TABLE_READ_OP = 4'b1011,
    OP_TABLE_WRITE_OP = 4'b1100,
    OP_XORF  = 4'b1101
  } ltd_op_t;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ltd_flags_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
  } ltd_dmem_req_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } ltd_tbl_req_t;
endpackage : ltd_pkg
